// ### hw/dwsr_mem_if.sv
// memory request carrier between the sequencer and the memory port
// assumes one request outstanding at a time
`default_nettype none
interface dwsr_mem_if;
    logic req;
    logic we;
    logic [14:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    modport client (output req, output we, output addr, output wdata,
                    input rdata, input ack);
    modport port (input req, input we, input addr, input wdata,
                  output rdata, output ack);
endinterface
`default_nettype wire

// ### hw/dwsr_memport.sv
// memory port: turns one request into held strobes until the memory acks
// assumes memory logic on the same clock, ack sampled while a strobe is high
`default_nettype none
module dwsr_memport
    import dwsr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // sequencer side
    dwsr_mem_if.port mi,
    // memory pins
    output logic [14:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic mem_rd,
    output logic mem_wr,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);
    logic ack_reg;
    logic [15:0] rdata_reg;

    // strobes held until ack; a request while busy cannot occur
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
        end else if ((mem_rd || mem_wr) && mem_ack) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
        end else if (mi.req) begin
            mem_rd <= !mi.we;
            mem_wr <= mi.we;
        end
    end

    // address and data latched with the request
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_addr <= 15'h0000;
            mem_wdata <= ACC_RESET;
        end else if (mi.req && !mem_rd && !mem_wr) begin
            mem_addr <= mi.addr;
            mem_wdata <= mi.wdata;
        end
    end

    // completion pulse with the read word
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
            rdata_reg <= ACC_RESET;
        end else begin
            ack_reg <= (mem_rd || mem_wr) && mem_ack;
            if (mem_rd && mem_ack) begin
                rdata_reg <= mem_rdata;
            end
        end
    end

    assign mi.ack = ack_reg;
    assign mi.rdata = rdata_reg;
endmodule
`default_nettype wire

// ### hw/dwsr_pkg.sv
// constants, opcodes, register indices and decode helpers of the pair shifter
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package dwsr_pkg;
    // ----------------------------------------------------------------
    // widths and fields
    // ----------------------------------------------------------------
    localparam int DWSR_DW = 16;
    localparam int DWSR_AW = 15;
    localparam int IND_BIT = 15;
    localparam int CNT_LSB = 0;
    localparam int CNT_W = 4;
    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [15:0] OP_DOUBLE_LOAD = 16'h8800;
    localparam logic [15:0] OP_DOUBLE_STORE = 16'h8C00;
    localparam logic [11:0] SH_ARITH_LEFT = 12'h801;
    localparam logic [11:0] SH_ARITH_RIGHT = 12'h821;
    localparam logic [11:0] SH_LOGIC_LEFT = 12'h802;
    localparam logic [11:0] SH_LOGIC_RIGHT = 12'h822;
    localparam logic [11:0] SH_ROT_LEFT = 12'h804;
    localparam logic [11:0] SH_ROT_RIGHT = 12'h824;
    // ----------------------------------------------------------------
    // register port map and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] REG_ACC_A = 2'h0;
    localparam logic [1:0] REG_ACC_B = 2'h1;
    localparam logic [1:0] REG_FLAGS = 2'h2;
    localparam int FLAG_OVF = 0;
    localparam int FLAG_EXT = 1;
    localparam logic [15:0] ACC_RESET = 16'h0000;
    localparam logic FLAG_RESET = 1'b0;

    typedef enum logic [6:0] {
        SHOP_NONE = 7'b0000001,
        SHOP_ARITH_LEFT = 7'b0000010,
        SHOP_ARITH_RIGHT = 7'b0000100,
        SHOP_LOGIC_LEFT = 7'b0001000,
        SHOP_LOGIC_RIGHT = 7'b0010000,
        SHOP_ROT_LEFT = 7'b0100000,
        SHOP_ROT_RIGHT = 7'b1000000
    } dwsr_shop_t;

    // shift group is recognised on the twelve bits above the count
    function automatic dwsr_shop_t dwsr_decode(input logic [15:0] w);
        case (w[15:CNT_W])
            SH_ARITH_LEFT: return SHOP_ARITH_LEFT;
            SH_ARITH_RIGHT: return SHOP_ARITH_RIGHT;
            SH_LOGIC_LEFT: return SHOP_LOGIC_LEFT;
            SH_LOGIC_RIGHT: return SHOP_LOGIC_RIGHT;
            SH_ROT_LEFT: return SHOP_ROT_LEFT;
            SH_ROT_RIGHT: return SHOP_ROT_RIGHT;
            default: return SHOP_NONE;
        endcase
    endfunction

    // zero field stands for sixteen places
    function automatic logic [4:0] dwsr_count(input logic [3:0] f);
        return (f == 4'h0) ? 5'h10 : {1'b0, f};
    endfunction
endpackage
`default_nettype wire

// ### hw/dwsr_shifter.sv
// combinational shifter on the B:A pair
// assumes the count is already decoded to 1..16
`default_nettype none
module dwsr_shifter
    import dwsr_pkg::*;
(
    // operands
    input wire dwsr_shop_t op,
    input wire logic [4:0] count,
    input wire logic [15:0] b_in,
    input wire logic [15:0] a_in,
    // results
    output logic [15:0] b_out,
    output logic [15:0] a_out,
    output logic ovf_wr,
    output logic ovf_val
);
    logic [31:0] v;
    logic [31:0] r;
    logic [63:0] rr;
    logic [30:0] mag;
    logic [30:0] lost;

    // b is the high word, a the low word
    always_comb begin
        v = {b_in, a_in};
        r = v;
        rr = {v, v};
        mag = v[30:0];
        lost = ~(31'h7FFFFFFF >> count);
        ovf_wr = 1'b0;
        ovf_val = 1'b0;
        unique case (op)
            SHOP_NONE: r = v;
            SHOP_ARITH_LEFT: begin
                r = {v[31], mag << count};
                ovf_wr = 1'b1;
                ovf_val = |((mag ^ {31{v[31]}}) & lost);
            end
            SHOP_ARITH_RIGHT: begin
                r = 32'($signed(v) >>> count);
                ovf_wr = 1'b1;
            end
            SHOP_LOGIC_LEFT: r = v << count;
            SHOP_LOGIC_RIGHT: r = v >> count;
            SHOP_ROT_LEFT: begin
                rr = {v, v} << count;
                r = rr[63:32];
            end
            SHOP_ROT_RIGHT: begin
                rr = {v, v} >> count;
                r = rr[31:0];
            end
        endcase
        b_out = r[31:16];
        a_out = r[15:0];
    end
endmodule
`default_nettype wire

// ### hw/dwsr_unit.sv
// double word load/store and B:A shift/rotate unit
// assumes the sequencer hands one instruction at a time, memory on REF_CLK
// Function
// - opcode word first, address word fetched from next location
// - address word carries a 15-bit operand address
// - top address bit set means fetch another address, any depth
// - double load puts word m into A, m+1 into B
// - double store writes A to m, B to m+1, accumulators kept
// - shifts treat B as high word and A as low word
// - four-bit count 1..15, zero means sixteen places
// - extend never changes; only arithmetic shifts touch overflow
// - arithmetic left keeps sign, drops from bit 14, zero-fills A
// - arithmetic left sets overflow if a dropped bit differs from sign
// - arithmetic right copies the sign into vacated high bits
// - arithmetic right discards low bits and clears overflow
// - logical right fills zeros at the top of B
// - logical left fills zeros at the bottom of A
// - rotate right moves A low bits into B high end
// - rotate left moves B high bits into A low end
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`default_nettype none
module dwsr_unit
    import dwsr_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // instruction handoff
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR_WORD,
    input wire logic [14:0] INSTR_ADDR,
    output logic INSTR_BUSY,
    output logic INSTR_DONE,
    // register port
    input wire logic [1:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // memory
    output logic [14:0] MEM_ADDR,
    output logic [15:0] MEM_WDATA,
    output logic MEM_RD,
    output logic MEM_WR,
    input wire logic [15:0] MEM_RDATA,
    input wire logic MEM_ACK
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_FIRST = 5'b00100,
        ST_SECOND = 5'b01000,
        ST_DONE = 5'b10000
    } dwsr_state_t;

    dwsr_state_t state_reg;
    dwsr_state_t state_next;
    logic [15:0] a_reg;
    logic [15:0] b_reg;
    logic ovf_reg;
    logic ext_reg;
    logic load_reg;
    logic busy_reg;
    logic done_reg;
    logic [15:0] rdata_reg;
    logic [14:0] oper_reg;
    logic req_reg;
    logic we_reg;
    logic [14:0] maddr_reg;
    logic [15:0] mwdata_reg;
    dwsr_shop_t sh_op;
    logic [4:0] sh_cnt;
    logic [15:0] sh_b;
    logic [15:0] sh_a;
    logic sh_ovf_wr;
    logic sh_ovf_val;
    logic is_load;
    logic is_store;
    logic take;
    logic sh_take;
    logic sw_wr;

    dwsr_mem_if mi ();

    // ----------------------------------------------------------------
    // decode and submodules
    // ----------------------------------------------------------------
    // shifts finish in the taking cycle, so decode straight off the port
    assign sh_op = dwsr_decode(INSTR_WORD);
    assign sh_cnt = dwsr_count(INSTR_WORD[CNT_LSB +: CNT_W]);
    assign is_load = (INSTR_WORD == OP_DOUBLE_LOAD);
    assign is_store = (INSTR_WORD == OP_DOUBLE_STORE);
    assign take = (state_reg == ST_IDLE) && INSTR_VALID;
    assign sh_take = take && (sh_op != SHOP_NONE);
    // software writes are shut out while a memory instruction runs
    assign sw_wr = REG_WR && !busy_reg;

    dwsr_shifter u_shift (
        .op(sh_op),
        .count(sh_cnt),
        .b_in(b_reg),
        .a_in(a_reg),
        .b_out(sh_b),
        .a_out(sh_a),
        .ovf_wr(sh_ovf_wr),
        .ovf_val(sh_ovf_val)
    );

    dwsr_memport u_mem (
        .clk(REF_CLK),
        .srst(SRST),
        .mi(mi.port),
        .mem_addr(MEM_ADDR),
        .mem_wdata(MEM_WDATA),
        .mem_rd(MEM_RD),
        .mem_wr(MEM_WR),
        .mem_rdata(MEM_RDATA),
        .mem_ack(MEM_ACK)
    );

    assign mi.req = req_reg;
    assign mi.we = we_reg;
    assign mi.addr = maddr_reg;
    assign mi.wdata = mwdata_reg;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // next state; unknown opcodes finish at once with no effect
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take && (is_load || is_store)) begin
                    state_next = ST_ADDR;
                end else if (take) begin
                    state_next = ST_DONE;
                end
            end
            ST_ADDR: begin
                if (mi.ack && !mi.rdata[IND_BIT]) begin
                    state_next = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (mi.ack) begin
                    state_next = ST_SECOND;
                end
            end
            ST_SECOND: begin
                if (mi.ack) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: state_next = ST_IDLE;
        endcase
    end

    // state, busy and done flags
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg <= (state_next != ST_IDLE);
            done_reg <= (state_reg == ST_DONE);
        end
    end

    // kind of memory instruction, held for the whole sequence
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            load_reg <= 1'b0;
        end else if (take) begin
            load_reg <= is_load;
        end
    end

    // memory requests; each one waits for the ack of the previous
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            req_reg <= 1'b0;
            we_reg <= 1'b0;
            maddr_reg <= 15'h0000;
            mwdata_reg <= ACC_RESET;
            oper_reg <= 15'h0000;
        end else begin
            req_reg <= 1'b0;
            if (take && (is_load || is_store)) begin
                req_reg <= 1'b1;
                we_reg <= 1'b0;
                maddr_reg <= 15'(INSTR_ADDR + 15'h0001);
            end else if ((state_reg == ST_ADDR) && mi.ack) begin
                req_reg <= 1'b1;
                maddr_reg <= mi.rdata[DWSR_AW-1:0];
                if (mi.rdata[IND_BIT]) begin
                    we_reg <= 1'b0;
                end else begin
                    oper_reg <= mi.rdata[DWSR_AW-1:0];
                    we_reg <= !load_reg;
                    mwdata_reg <= a_reg;
                end
            end else if ((state_reg == ST_FIRST) && mi.ack) begin
                req_reg <= 1'b1;
                maddr_reg <= 15'(oper_reg + 15'h0001);
                we_reg <= !load_reg;
                mwdata_reg <= b_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // accumulators and flags
    // ----------------------------------------------------------------
    // datapath results take priority over software writes
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            a_reg <= ACC_RESET;
            b_reg <= ACC_RESET;
        end else if (sh_take) begin
            a_reg <= sh_a;
            b_reg <= sh_b;
        end else if ((state_reg == ST_FIRST) && mi.ack && load_reg) begin
            a_reg <= mi.rdata;
        end else if ((state_reg == ST_SECOND) && mi.ack && load_reg) begin
            b_reg <= mi.rdata;
        end else if (sw_wr && (REG_ADDR == REG_ACC_A)) begin
            a_reg <= REG_WDATA;
        end else if (sw_wr && (REG_ADDR == REG_ACC_B)) begin
            b_reg <= REG_WDATA;
        end
    end

    // overflow moves on arithmetic shifts and software writes; extend only from software
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ovf_reg <= FLAG_RESET;
            ext_reg <= FLAG_RESET;
        end else begin
            if (sh_take && sh_ovf_wr) begin
                ovf_reg <= sh_ovf_val;
            end else if (sw_wr && !sh_take && (REG_ADDR == REG_FLAGS)) begin
                ovf_reg <= REG_WDATA[FLAG_OVF];
            end
            if (sw_wr && !sh_take && (REG_ADDR == REG_FLAGS)) begin
                ext_reg <= REG_WDATA[FLAG_EXT];
            end
        end
    end

    // read data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rdata_reg <= 16'h0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                REG_ACC_A: rdata_reg <= a_reg;
                REG_ACC_B: rdata_reg <= b_reg;
                REG_FLAGS: rdata_reg <= {14'h0000, ext_reg, ovf_reg};
                default: rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign INSTR_BUSY = busy_reg;
    assign INSTR_DONE = done_reg;
    assign REG_RDATA = rdata_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);

    a_addr_fetch_next: assert property (
        take && (is_load || is_store) |=> mi.req && !mi.we
            && (mi.addr == 15'($past(INSTR_ADDR) + 15'h0001)))
        else $error("address word not fetched from next location");

    a_operand_address: assert property (
        (state_reg == ST_ADDR) && mi.ack && !mi.rdata[IND_BIT]
            |=> mi.req && (mi.addr == $past(mi.rdata[14:0]))
            && (state_reg == ST_FIRST))
        else $error("operand address not taken from address word");

    a_indirect_level: assert property (
        (state_reg == ST_ADDR) && mi.ack && mi.rdata[IND_BIT]
            |=> (state_reg == ST_ADDR) && mi.req && !mi.we
            && (mi.addr == $past(mi.rdata[14:0])))
        else $error("indirect level not followed");

    a_load_pair: assert property (
        (state_reg == ST_FIRST) && mi.ack && load_reg
            |=> (a_reg == $past(mi.rdata)) && !mi.we
            && (mi.addr == 15'(oper_reg + 15'h0001)))
        else $error("double load low word or next address wrong");

    a_store_pair: assert property (
        (state_reg == ST_FIRST) && mi.ack && !load_reg
            |=> mi.we && (mi.wdata == b_reg)
            && (mi.addr == 15'(oper_reg + 15'h0001)))
        else $error("double store high word wrong");

    a_store_keeps_acc: assert property (
        busy_reg && !load_reg |=> $stable(a_reg) && $stable(b_reg))
        else $error("accumulator changed during double store");

    a_swap_sixteen: assert property (
        sh_take && (sh_op == SHOP_ROT_LEFT) && (INSTR_WORD[3:0] == 4'h0)
            |=> (a_reg == $past(b_reg)) && (b_reg == $past(a_reg)))
        else $error("zero count did not swap the words");

    a_extend_fixed: assert property (
        sh_take |=> $stable(ext_reg))
        else $error("shift changed extend");

    a_ovf_logical: assert property (
        sh_take && (sh_op != SHOP_ARITH_LEFT) && (sh_op != SHOP_ARITH_RIGHT)
            |=> $stable(ovf_reg))
        else $error("logical shift or rotate changed overflow");

    a_arith_left_one: assert property (
        sh_take && (sh_op == SHOP_ARITH_LEFT) && (INSTR_WORD[3:0] == 4'h1)
            |=> (ovf_reg == ($past(b_reg[15]) != $past(b_reg[14])))
            && (b_reg[15] == $past(b_reg[15])) && !a_reg[0])
        else $error("arithmetic left by one wrong");

    a_arith_right_sign: assert property (
        sh_take && (sh_op == SHOP_ARITH_RIGHT)
            |=> !ovf_reg && (b_reg[15] == $past(b_reg[15]))
            && (b_reg[14] == $past(b_reg[15])))
        else $error("arithmetic right sign or overflow wrong");

    a_logic_fill: assert property (
        sh_take && ((sh_op == SHOP_LOGIC_RIGHT) || (sh_op == SHOP_LOGIC_LEFT))
            |=> ($past(sh_op) == SHOP_LOGIC_RIGHT) ? !b_reg[15] : !a_reg[0])
        else $error("logical shift fill not zero");

    a_rotate_wrap: assert property (
        sh_take && (INSTR_WORD[3:0] == 4'h1)
            && ((sh_op == SHOP_ROT_LEFT) || (sh_op == SHOP_ROT_RIGHT))
            |=> ($past(sh_op) == SHOP_ROT_LEFT) ? (a_reg[0] == $past(b_reg[15]))
            : (b_reg[15] == $past(a_reg[0])))
        else $error("rotate did not wrap the pair");

    c_load_indirect: cover property (
        (state_reg == ST_ADDR) && mi.ack && mi.rdata[IND_BIT] && load_reg);
    c_store_done: cover property (busy_reg && !load_reg ##1 done_reg);
    c_arith_left_ovf: cover property (sh_take && (sh_op == SHOP_ARITH_LEFT) ##1 ovf_reg);
    c_swap: cover property (sh_take && (INSTR_WORD[3:0] == 4'h0));
endmodule
`default_nettype wire

// ### sim/dwsr_mem_model.sv
// memory and sequencer far side of the pair shifter's memory pins
// assumes one strobe at a time, acked on the clock of the unit
`default_nettype none
module dwsr_mem_model (
    // clock and pacing
    input wire logic clk,
    input wire logic slow,
    // memory pins
    input wire logic [14:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic mem_rd,
    input wire logic mem_wr,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    // -------------------------------------------------
    // storage and answer
    // -------------------------------------------------
    logic [15:0] store [0:32767];
    logic [15:0] last = 16'h0000;
    int cnt = 0;
    int lim = 0;
    // ack may come in the first strobe cycle or after a random stall
    always_comb mem_ack = (mem_rd | mem_wr) && (cnt >= lim);
    // released bus shows the inverse of the last word, not a stale copy
    always_comb mem_rdata = (mem_rd && mem_ack) ? store[mem_addr] : ~last;
    // write on the ack edge, then draw the next stall
    always @(posedge clk) begin
        if ((mem_rd | mem_wr) && mem_ack) begin
            if (mem_wr) begin
                store[mem_addr] <= mem_wdata;
            end else begin
                last <= store[mem_addr];
            end
            cnt <= 0;
            lim <= slow ? int'($urandom_range(3, 0)) : 0;
        end else if (mem_rd | mem_wr) begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ### sim/test_double_word_shift_rotate_unit.sv
// bench: shifts, double load and store checked against an integer model
// assumes the unit and the memory model share REF_CLK
`default_nettype none
module test_double_word_shift_rotate_unit
    import dwsr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------
    // signals
    // -------------------------------------------------
    logic REF_CLK = 1'b0;
    logic SRST = 1'b1;
    logic INSTR_VALID = 1'b0;
    logic [15:0] INSTR_WORD = 16'h0000;
    logic [14:0] INSTR_ADDR = 15'h0000;
    logic [1:0] REG_ADDR = 2'h0;
    logic [15:0] REG_WDATA = 16'h0000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic slow = 1'b0;
    logic INSTR_BUSY, INSTR_DONE, MEM_RD, MEM_WR, MEM_ACK;
    logic [15:0] REG_RDATA, MEM_WDATA, MEM_RDATA, a_m, b_m, rd;
    logic [14:0] MEM_ADDR;
    logic ovf_m, ext_m;
    logic [11:0] ops [6];
    int err_total = 0;
    int tests_run = 0;
    always #5 REF_CLK = ~REF_CLK;
    dwsr_unit dut (.REF_CLK(REF_CLK), .SRST(SRST), .INSTR_VALID(INSTR_VALID),
        .INSTR_WORD(INSTR_WORD), .INSTR_ADDR(INSTR_ADDR), .INSTR_BUSY(INSTR_BUSY),
        .INSTR_DONE(INSTR_DONE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
        .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));
    dwsr_mem_model mem_m (.clk(REF_CLK), .slow(slow), .mem_addr(MEM_ADDR),
        .mem_wdata(MEM_WDATA), .mem_rd(MEM_RD), .mem_wr(MEM_WR),
        .mem_rdata(MEM_RDATA), .mem_ack(MEM_ACK));
    // -------------------------------------------------
    // tasks
    // -------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d of %0d compares", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge REF_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge REF_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask
    task automatic exec(input logic [15:0] w, input logic [14:0] p);
        int i;
        @(posedge REF_CLK);
        INSTR_VALID <= 1'b1;
        INSTR_WORD <= w;
        INSTR_ADDR <= p;
        @(posedge REF_CLK);
        INSTR_VALID <= 1'b0;
        for (i = 0; i < 500; i++) begin
            #1;
            if (i == 0) check(16'(INSTR_BUSY), 16'h0001);
            if (INSTR_DONE === 1'b1) break;
            @(posedge REF_CLK);
        end
        if (i == 500) begin
            err_total++;
            end_of_test();
        end
        check(16'(INSTR_BUSY), 16'h0000);
    endtask
    task automatic load_regs();
        reg_wr(REG_ACC_A, a_m);
        reg_wr(REG_ACC_B, b_m);
        reg_wr(REG_FLAGS, {14'h0000, ext_m, ovf_m});
    endtask
    task automatic check_regs();
        reg_rd(REG_ACC_A, rd);
        check(rd, a_m);
        reg_rd(REG_ACC_B, rd);
        check(rd, b_m);
        reg_rd(REG_FLAGS, rd);
        check(rd, {14'h0000, ext_m, ovf_m});
    endtask
    // one place per step on the 32-bit B:A value
    task automatic shift_model(input int k, input logic [3:0] f);
        logic [31:0] v;
        int n;
        v = {b_m, a_m};
        n = (f == 4'h0) ? 16 : int'(f);
        if (k < 2) ovf_m = 1'b0;
        for (int i = 0; i < n; i++) begin
            case (k)
                0: begin
                    if (v[30] != v[31]) ovf_m = 1'b1;
                    v = {v[31], v[29:0], 1'b0};
                end
                1: v = {v[31], v[31:1]};
                2: v = {v[30:0], 1'b0};
                3: v = {1'b0, v[31:1]};
                4: v = {v[30:0], v[31]};
                default: v = {v[0], v[31:1]};
            endcase
        end
        {b_m, a_m} = v;
    endtask
    // -------------------------------------------------
    // main sequence
    // -------------------------------------------------
    initial begin
        logic [3:0] f;
        ops = '{SH_ARITH_LEFT, SH_ARITH_RIGHT, SH_LOGIC_LEFT, SH_LOGIC_RIGHT,
                SH_ROT_LEFT, SH_ROT_RIGHT};
        void'($urandom(32'h54E7));
        repeat (6) @(posedge REF_CLK);
        SRST <= 1'b0;
        {a_m, b_m, ext_m, ovf_m} = '0;
        check_regs();
        // unmapped index swallows writes and reads zero
        reg_wr(2'h3, 16'hFFFF);
        reg_rd(2'h3, rd);
        check(rd, 16'h0000);
        // every shift kind at counts 16, 1, 15 and random
        for (int k = 0; k < 6; k++) begin
            for (int j = 0; j < 4; j++) begin
                f = (j == 0) ? 4'h0 : (j == 1) ? 4'h1 : (j == 2) ? 4'hF : 4'($urandom);
                a_m = 16'($urandom);
                b_m = 16'($urandom);
                ext_m = 1'($urandom);
                ovf_m = 1'($urandom);
                load_regs();
                exec({ops[k], f}, 15'($urandom));
                shift_model(k, f);
                check_regs();
            end
        end
        // an opcode outside the group finishes with no effect
        exec(16'h0000, 15'h0000);
        check_regs();
        // loads: direct with quick memory, two indirect levels with stalls
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            mem_m.store[15'h0101] = s ? 16'h8200 : 16'h7FFF;
            mem_m.store[15'h0200] = 16'h8300;
            mem_m.store[15'h0300] = 16'h7FFF;
            mem_m.store[15'h7FFF] = 16'($urandom);
            mem_m.store[15'h0000] = 16'($urandom);
            exec(OP_DOUBLE_LOAD, 15'h0100);
            a_m = mem_m.store[15'h7FFF];
            b_m = mem_m.store[15'h0000];
            check_regs();
            // store keeps the pair and writes m then m+1
            mem_m.store[15'h0501] = 16'h0400;
            a_m = 16'($urandom);
            b_m = 16'($urandom);
            load_regs();
            exec(OP_DOUBLE_STORE, 15'h0500);
            check(mem_m.store[15'h0400], a_m);
            check(mem_m.store[15'h0401], b_m);
            check_regs();
        end
        end_of_test();
    end
endmodule
`default_nettype wire
